// [logic/bst_regs.vh]
// bst_regs.vh: constants for the boundary-scan test port
// assumes inclusion by bare name from the design files
`ifndef BST_REGS_VH
`define BST_REGS_VH
`define BST_IR_LEN 10
`define BST_IR_ONES 10'h3FF
`define BST_IR_EXTEST 10'h00F
`define BST_IR_SAMPLE 10'h005
`define BST_IR_IDCODE 10'h006
`define BST_IR_USERCODE 10'h007
`define BST_IR_CLAMP 10'h00A
`define BST_IR_HIGHZ 10'h00B
`define BST_IR_CAPTURE 10'h001
`define BST_CELL_BITS 3
`define BST_CELL_OUT 0
`define BST_CELL_OE 1
`define BST_CELL_IN 2
`define BST_ID_RESET 32'h12345679
`define BST_TLR 4'h0
`define BST_RTI 4'h1
`define BST_SEL_DR 4'h2
`define BST_CAP_DR 4'h3
`define BST_SH_DR 4'h4
`define BST_EX1_DR 4'h5
`define BST_PAU_DR 4'h6
`define BST_EX2_DR 4'h7
`define BST_UPD_DR 4'h8
`define BST_SEL_IR 4'h9
`define BST_CAP_IR 4'hA
`define BST_SH_IR 4'hB
`define BST_EX1_IR 4'hC
`define BST_PAU_IR 4'hD
`define BST_EX2_IR 4'hE
`define BST_UPD_IR 4'hF
`endif

// [logic/bst_cell.v]
// bst_cell.v: one 3-bit boundary-scan cell for a user I/O pin
// assumes the test port drives global capture, shift, update and mode strobes
`timescale 1ns/1ps
`include "bst_regs.vh"
module bst_cell (
   input wire clock_in,               // system clock
   input wire sys_rst_in,             // sync reset, high
   input wire capture_in,             // capture strobe
   input wire shift_in,               // shift strobe
   input wire update_in,              // update strobe
   input wire mode_in,                // 1 selects test data onto pin
   input wire hiz_in,                 // force output disable
   input wire core_output_value,      // core output value
   input wire core_output_enable_value, // core output enable value
   input wire pin_in,                 // pin input value
   input wire cell_serial_in,         // chain in
   output wire cell_serial_out,       // chain out
   output wire pin_out,               // value toward pin
   output wire pin_oe                 // enable toward pin
);
   reg [`BST_CELL_BITS-1:0] cap_ff;
   reg [1:0] upd_ff;
   always @(posedge clock_in) begin
      if (sys_rst_in) begin
         cap_ff <= 3'h0;
         upd_ff <= 2'h0;
      end else begin
         if (capture_in)
            cap_ff <= {pin_in, core_output_enable_value, core_output_value};
         else if (shift_in)
            cap_ff <= {cell_serial_in, cap_ff[2:1]};
         if (update_in)
            upd_ff <= cap_ff[1:0];
      end
   end
   assign cell_serial_out = cap_ff[0];
   assign pin_out = mode_in ? upd_ff[`BST_CELL_OUT] : core_output_value;
   assign pin_oe = hiz_in ? 1'b0 : (mode_in ? upd_ff[`BST_CELL_OE] : core_output_enable_value);
endmodule // bst_cell

// [logic/bst_port.v]
// bst_port.v: four-wire boundary-scan test port with instruction, bypass,
// identification and boundary-scan registers
// assumes test pins are asynchronous and sampled by clock_in (tck far slower)
`timescale 1ns/1ps
`include "bst_regs.vh"
module bst_port #(
   parameter NUM_PINS = 8,
   parameter [31:0] ID_CODE = `BST_ID_RESET, // arbitrary value
   parameter [31:0] USER_CODE = 32'hFFFFFFFF
) (
   input wire clock_in,                          // 25 MHz system clock
   input wire sys_rst_in,                        // sync reset, high (power-up)
   input wire tck_in,                            // test clock pin
   input wire tms_in,                            // test mode select pin
   input wire tdi_in,                            // test data in pin
   output reg tdo_out,                           // test data out value
   output reg tdo_oe_n_out,                      // low while tdo driven
   input wire [NUM_PINS-1:0] core_out_in,        // core output values
   input wire [NUM_PINS-1:0] core_oe_in,         // core output enables
   input wire [NUM_PINS-1:0] pin_in,             // pin input levels
   output reg [NUM_PINS-1:0] pin_out,            // pin output values
   output reg [NUM_PINS-1:0] pin_oe_out,         // pin output enables, high drives
   output reg test_mode_out                      // high while cells own the pins
);
   // only tck, tms, tdi, tdo exist; no reset pin, no cells on them
   reg [2:0] tck_sync_ff;
   reg [1:0] tms_sync_ff;
   reg [1:0] tdi_sync_ff;
   always @(posedge clock_in) begin
      if (sys_rst_in) begin
         tck_sync_ff <= 3'h0;
         tms_sync_ff <= 2'h3;
         tdi_sync_ff <= 2'h3;
      end else begin
         tck_sync_ff <= {tck_sync_ff[1:0], tck_in};
         tms_sync_ff <= {tms_sync_ff[0], tms_in};
         tdi_sync_ff <= {tdi_sync_ff[0], tdi_in};
      end
   end
   wire tck_rise = tck_sync_ff[1] & ~tck_sync_ff[2];
   wire tck_fall = ~tck_sync_ff[1] & tck_sync_ff[2];
   wire tms_s = tms_sync_ff[1];
   wire tdi_s = tdi_sync_ff[1];

   reg [3:0] state_ff;
   reg [3:0] nxt_state;
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         `BST_TLR: nxt_state = tms_s ? `BST_TLR : `BST_RTI;
         `BST_RTI: nxt_state = tms_s ? `BST_SEL_DR : `BST_RTI;
         `BST_SEL_DR: nxt_state = tms_s ? `BST_SEL_IR : `BST_CAP_DR;
         `BST_CAP_DR: nxt_state = tms_s ? `BST_EX1_DR : `BST_SH_DR;
         `BST_SH_DR: nxt_state = tms_s ? `BST_EX1_DR : `BST_SH_DR;
         `BST_EX1_DR: nxt_state = tms_s ? `BST_UPD_DR : `BST_PAU_DR;
         `BST_PAU_DR: nxt_state = tms_s ? `BST_EX2_DR : `BST_PAU_DR;
         `BST_EX2_DR: nxt_state = tms_s ? `BST_UPD_DR : `BST_SH_DR;
         `BST_UPD_DR: nxt_state = tms_s ? `BST_SEL_DR : `BST_RTI;
         `BST_SEL_IR: nxt_state = tms_s ? `BST_TLR : `BST_CAP_IR;
         `BST_CAP_IR: nxt_state = tms_s ? `BST_EX1_IR : `BST_SH_IR;
         `BST_SH_IR: nxt_state = tms_s ? `BST_EX1_IR : `BST_SH_IR;
         `BST_EX1_IR: nxt_state = tms_s ? `BST_UPD_IR : `BST_PAU_IR;
         `BST_PAU_IR: nxt_state = tms_s ? `BST_EX2_IR : `BST_PAU_IR;
         `BST_EX2_IR: nxt_state = tms_s ? `BST_UPD_IR : `BST_SH_IR;
         `BST_UPD_IR: nxt_state = tms_s ? `BST_SEL_DR : `BST_RTI;
         default: nxt_state = `BST_TLR;
      endcase
   end
   always @(posedge clock_in) begin
      if (sys_rst_in)
         state_ff <= `BST_TLR;
      else if (tck_rise)
         state_ff <= nxt_state;
   end

   // instruction register: shift stage and held stage
   reg [`BST_IR_LEN-1:0] ir_sh_ff;
   reg [`BST_IR_LEN-1:0] ir_ff;
   always @(posedge clock_in) begin
      if (sys_rst_in) begin
         ir_sh_ff <= `BST_IR_IDCODE;
         ir_ff <= `BST_IR_IDCODE;
      end else if (tck_rise) begin
         case (state_ff)
            `BST_CAP_IR: ir_sh_ff <= `BST_IR_CAPTURE;
            `BST_SH_IR: ir_sh_ff <= {tdi_s, ir_sh_ff[`BST_IR_LEN-1:1]};
            `BST_UPD_IR: ir_ff <= ir_sh_ff;
            default: ir_ff <= ir_ff;
         endcase
         // load on entry, so pins go functional on the fifth tms-high edge, not one later
         if (nxt_state == `BST_TLR)
            ir_ff <= `BST_IR_IDCODE;
      end
   end

   // decode used both for path select and for the cell update strobe
   function is_bsr_sel;
      input [`BST_IR_LEN-1:0] ir;
      begin
         is_bsr_sel = (ir == `BST_IR_EXTEST) || (ir == `BST_IR_SAMPLE);
      end
   endfunction
   wire sel_bsr = is_bsr_sel(ir_ff);
   wire sel_id = (ir_ff == `BST_IR_IDCODE) || (ir_ff == `BST_IR_USERCODE);
   wire mode_test = (ir_ff == `BST_IR_EXTEST) || (ir_ff == `BST_IR_CLAMP) || (ir_ff == `BST_IR_HIGHZ);
   wire force_hiz = (ir_ff == `BST_IR_HIGHZ);

   // global cell strobes, one system clock wide at rising tck
   wire cell_capture = tck_rise && state_ff == `BST_CAP_DR && sel_bsr;
   wire cell_shift = tck_rise && state_ff == `BST_SH_DR && sel_bsr;
   wire cell_update = tck_rise && state_ff == `BST_UPD_DR && is_bsr_sel(ir_ff) &&
      ir_ff != `BST_IR_CLAMP;

   // bypass (also the path for clamp, highz and unknown codes) and identification
   reg bypass_ff;
   reg [31:0] id_ff;
   always @(posedge clock_in) begin
      if (sys_rst_in) begin
         bypass_ff <= 1'b0;
         id_ff <= 32'h0;
      end else if (tck_rise) begin
         if (state_ff == `BST_CAP_DR) begin
            bypass_ff <= 1'b0;
            id_ff <= (ir_ff == `BST_IR_USERCODE) ? USER_CODE : ID_CODE;
         end else if (state_ff == `BST_SH_DR) begin
            bypass_ff <= tdi_s;
            id_ff <= {tdi_s, id_ff[31:1]};
         end
      end
   end

   // boundary-scan chain of cells, one per user pin, none on the clock_in pin
   wire [NUM_PINS:0] chain;
   wire [NUM_PINS-1:0] cell_pin_out;
   wire [NUM_PINS-1:0] cell_pin_oe;
   assign chain[NUM_PINS] = tdi_s;
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_cell
         bst_cell u_cell (
            .clock_in(clock_in),
            .sys_rst_in(sys_rst_in),
            .capture_in(cell_capture),
            .shift_in(cell_shift),
            .update_in(cell_update),
            .mode_in(mode_test),
            .hiz_in(force_hiz),
            .core_output_value(core_out_in[gi]),
            .core_output_enable_value(core_oe_in[gi]),
            .pin_in(pin_in[gi]),
            .cell_serial_in(chain[gi+1]),
            .cell_serial_out(chain[gi]),
            .pin_out(cell_pin_out[gi]),
            .pin_oe(cell_pin_oe[gi])
         );
      end
   endgenerate

   // pin outputs registered: one system cycle of latency against tck is negligible
   always @(posedge clock_in) begin
      if (sys_rst_in) begin
         pin_out <= {NUM_PINS{1'b0}};
         pin_oe_out <= {NUM_PINS{1'b0}};
         test_mode_out <= 1'b0;
      end else begin
         pin_out <= cell_pin_out;
         pin_oe_out <= cell_pin_oe;
         test_mode_out <= mode_test;
      end
   end

   // serial out chosen by state and instruction, changed only on falling tck
   reg dr_bit;
   always @* begin
      dr_bit = bypass_ff;
      if (sel_bsr)
         dr_bit = chain[0];
      else if (sel_id)
         dr_bit = id_ff[0];
   end
   wire in_shift = (state_ff == `BST_SH_DR) || (state_ff == `BST_SH_IR);
   always @(posedge clock_in) begin
      if (sys_rst_in) begin
         tdo_out <= 1'b0;
         tdo_oe_n_out <= 1'b1;
      end else if (tck_fall) begin
         tdo_oe_n_out <= ~in_shift;
         tdo_out <= (state_ff == `BST_SH_IR) ? ir_sh_ff[0] : dr_bit;
      end
   end
endmodule // bst_port

// [verification/bst_port_sva.sv]
// bst_port_sva.sv: port-level checks for the boundary-scan test port
// assumes tck_in is slow against clock_in (eight clocks a period)
`timescale 1ns/1ps
module bst_port_sva #(parameter NUM_PINS = 8) (
   input wire clock_in, // system clock
   input wire sys_rst_in, // sync reset
   input wire tck_in, // test clock
   input wire tms_in, // mode select
   input wire tdo_out, // serial out
   input wire tdo_oe_n_out, // low drives tdo
   input wire [NUM_PINS-1:0] core_out_in, // core values
   input wire [NUM_PINS-1:0] core_oe_in, // core enables
   input wire [NUM_PINS-1:0] pin_out, // pin values
   input wire [NUM_PINS-1:0] pin_oe_out, // pin enables
   input wire test_mode_out // cells own pins
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   logic tck_q;
   logic [2:0] hi_cnt;
   // rising test clocks seen with tms high in a row; saturates so it cannot wrap
   always @(posedge clock_in) begin
      tck_q <= tck_in;
      if (sys_rst_in) hi_cnt <= 3'h0;
      else if (tck_in && !tck_q) hi_cnt <= !tms_in ? 3'h0 : (hi_cnt == 3'h7 ? hi_cnt : hi_cnt + 3'h1);
   end
   reset_idle_a: assert property (disable iff (1'b0) sys_rst_in |=> tdo_oe_n_out && !tdo_out)
      else $error("tdo not idle after reset");
   reset_pins_a: assert property (disable iff (1'b0) sys_rst_in |=> pin_oe_out == '0 && !test_mode_out)
      else $error("pins not released in reset");
   tdo_edge_a: assert property ($changed(tdo_out) |-> !$past(tck_in) && $past(tck_in, 6))
      else $error("tdo moved away from falling tck");
   oe_edge_a: assert property ($changed(tdo_oe_n_out) |-> !$past(tck_in) && $past(tck_in, 6))
      else $error("tdo enable moved away from falling tck");
   tlr_quiet_a: assert property (hi_cnt >= 3'h6 |-> tdo_oe_n_out && !test_mode_out)
      else $error("not idle after five tms high");
   tlr_pins_a: assert property (hi_cnt >= 3'h6 |-> pin_oe_out == $past(core_oe_in))
      else $error("pins not functional after tms reset");
   func_pins_a: assert property (!$past(sys_rst_in) && !test_mode_out && !$past(test_mode_out)
      && !$past(test_mode_out, 2) |-> pin_out == $past(core_out_in))
      else $error("pin value not from core in functional mode");
   shift_exit_a: assert property (!tdo_oe_n_out |-> hi_cnt < 3'h3)
      else $error("tdo still driven after leaving shift");
endmodule // bst_port_sva
bind bst_port bst_port_sva #(.NUM_PINS(NUM_PINS)) u_sva (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .tck_in(tck_in),
   .tms_in(tms_in), .tdo_out(tdo_out), .tdo_oe_n_out(tdo_oe_n_out), .core_out_in(core_out_in), .core_oe_in(core_oe_in),
   .pin_out(pin_out), .pin_oe_out(pin_oe_out), .test_mode_out(test_mode_out));

// [verification/bst_tap_model.sv]
// bst_tap_model.sv: behavioural test controller on the four test pins
// assumes the bench calls xfer; tck rests low, tms and tdi rest high
`timescale 1ns/1ps
module bst_tap_model (
   input wire clock_in, // system clock
   input wire tdo_in, // device serial out
   input wire tdo_oe_n_in, // low while tdo driven
   output logic tck_out = 1'b0, // test clock
   output logic tms_out = 1'b1, // mode select
   output logic tdi_out = 1'b1 // serial data
);
   logic tdo_last = 1'b0;
   // released tdo has no pull; the inverse keeps a stale bit from passing
   wire tdo_seen = tdo_oe_n_in ? ~tdo_last : tdo_in;
   always @(posedge clock_in) if (!tdo_oe_n_in) tdo_last <= tdo_in;
   task automatic xfer(input [63:0] tms_v, input [63:0] tdi_v, input int n, output [63:0] tdo_v,
      output [63:0] oe_v);
      @(posedge clock_in);
      for (int i = 0; i < n; i++) begin
         tms_out <= tms_v[i];
         tdi_out <= tdi_v[i];
         repeat (4) @(posedge clock_in);
         tdo_v[i] = tdo_seen;
         oe_v[i] = tdo_oe_n_in;
         tck_out <= 1'b1;
         repeat (4) @(posedge clock_in);
         tck_out <= 1'b0;
      end
      tms_out <= 1'b1;
      tdi_out <= 1'b1;
   endtask
endmodule // bst_tap_model

// [verification/bst_port_tb_top.sv]
// bst_port_tb_top.sv: self-checking bench for the boundary-scan test port
// assumes the tap model owns the test pins; core inputs held quasi static
`timescale 1ns/1ps
`include "bst_regs.vh"
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin failures++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, a); end end
module bst_port_tb_top;
   localparam int NP = 8;
   localparam logic [31:0] ID = 32'h1357_9BDF; // arbitrary value
   logic clock_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [NP-1:0] core_out_in = 8'h96;
   logic [NP-1:0] core_oe_in = 8'hF0;
   logic [NP-1:0] pin_in = 8'h5A;
   wire tck, tms, tdi, tdo_out, tdo_oe_n_out, test_mode_out;
   wire [NP-1:0] pin_out, pin_oe_out;
   int failures = 0;
   int checks_done = 0;
   logic [63:0] q, oe;
   logic [23:0] cap_v, pat_v;
   logic [9:0] cp;
   logic [27:0] rows [8];
   initial forever #20 clock_in = ~clock_in;
   bst_port #(.NUM_PINS(NP), .ID_CODE(ID)) dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .tck_in(tck),
      .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo_out), .tdo_oe_n_out(tdo_oe_n_out), .core_out_in(core_out_in),
      .core_oe_in(core_oe_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
      .test_mode_out(test_mode_out));
   bst_tap_model tap (.clock_in(clock_in), .tdo_in(tdo_out), .tdo_oe_n_in(tdo_oe_n_out), .tck_out(tck),
      .tms_out(tms), .tdi_out(tdi));
   // tms 0,1,1,0,0 reaches shift-ir from reset or idle; ten bits, then update and idle
   task automatic ir(input [9:0] c);
      tap.xfer(64'hC006, {49'h0, c, 5'h0}, 17, q, oe);
      cp = q[14:5];
   endtask
   task automatic dr(input [31:0] d, input int n);
      tap.xfer((64'h3 << (n + 3)) | 64'h2, {28'h0, d, 4'h0}, n + 6, q, oe);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #1000000;
      failures++;
      tally_and_finish();
   end
   initial begin
      rows[0] = {`BST_IR_EXTEST, 8'hA5, 8'h3C, 2'b11};
      rows[1] = {`BST_IR_CLAMP, 8'hA5, 8'h3C, 2'b11};
      rows[2] = {`BST_IR_HIGHZ, 8'h00, 8'h00, 2'b10};
      rows[3] = {`BST_IR_SAMPLE, 8'h96, 8'hF0, 2'b01};
      rows[4] = {`BST_IR_IDCODE, 8'h96, 8'hF0, 2'b01};
      rows[5] = {`BST_IR_USERCODE, 8'h96, 8'hF0, 2'b01};
      rows[6] = {10'h3FF, 8'h96, 8'hF0, 2'b01};
      rows[7] = {10'h2AA, 8'h96, 8'hF0, 2'b01};
      for (int i = 0; i < NP; i++) begin
         cap_v[3*i +: 3] = {pin_in[i], core_oe_in[i], core_out_in[i]};
         pat_v[3*i +: 3] = {1'b0, rows[0][2+i], rows[0][10+i]};
      end
      repeat (5) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      repeat (4) @(posedge clock_in);
      `CHK("tdo_oe_n", 1'b1, tdo_oe_n_out)
      dr(32'h0, 32);
      `CHK("idcode", ID, q[35:4])
      `CHK("tdo_oe_n walk", 38'h30_0000_000F, oe[37:0])
      ir(`BST_IR_SAMPLE);
      `CHK("ir capture", 10'h001, cp)
      dr({8'h0, pat_v}, 24);
      `CHK("bsr capture", cap_v, q[27:4])
      ir(10'h3FF);
      dr(32'hB, 4);
      `CHK("bypass path", 4'h6, q[7:4])
      for (int r = 0; r < 8; r++) begin
         ir(rows[r][27:18]);
         repeat (4) @(posedge clock_in);
         `CHK("test_mode", rows[r][1], test_mode_out)
         `CHK("pin_oe", rows[r][9:2], pin_oe_out)
         if (rows[r][0]) `CHK("pin_out", rows[r][17:10], pin_out)
      end
      ir(`BST_IR_USERCODE);
      dr(32'h0, 32);
      `CHK("usercode", 32'hFFFFFFFF, q[35:4])
      // leave shift through six tms-high clocks while cells own the pins
      ir(`BST_IR_EXTEST);
      tap.xfer(64'h1F9, 64'h0, 9, q, oe);
      repeat (4) @(posedge clock_in);
      `CHK("mode after tms reset", 1'b0, test_mode_out)
      dr(32'h0, 32);
      `CHK("idcode after tms reset", ID, q[35:4])
      ir(`BST_IR_CLAMP);
      sys_rst_in <= 1'b1;
      repeat (5) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      repeat (4) @(posedge clock_in);
      `CHK("mode after reset", 1'b0, test_mode_out)
      `CHK("pin_oe after reset", core_oe_in, pin_oe_out)
      tally_and_finish();
   end
endmodule // bst_port_tb_top
